// ==== core/pus_pkg.sv ====
`default_nettype none
package pus_pkg;
	// ----------------------------------------------------------------
	// bus carriers
	// ----------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
	} pus_apb_req_t;

	typedef struct packed {
		logic [DATA_W-1:0] prdata;
		logic pready;
		logic pslverr;
	} pus_apb_rsp_t;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFF_CTRL = 12'h000;
	localparam logic [ADDR_W-1:0] OFF_INIT = 12'h004;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h008;
	localparam logic [ADDR_W-1:0] OFF_USER_OE = 12'h00c;
	localparam logic [ADDR_W-1:0] OFF_USER_OUT = 12'h010;

	// ctrl fields
	localparam int CTRL_PROGRAMMED_BIT = 0;
	localparam logic CTRL_PROGRAMMED_RST = 1'b0;

	// status fields
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_STATE_W = 2;
	localparam int STAT_PGOOD_BIT = 2;
	localparam int STAT_READY_BIT = 3;
	localparam int STAT_INIT_BUSY_BIT = 4;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 40;
	localparam int INIT_TIME_US = 300;
	localparam int INIT_CYCLES = INIT_TIME_US * CLK_MHZ;
	localparam int INIT_CNT_W = 24;

	typedef enum logic [1:0] {
		PUS_QUIESCENT,
		PUS_INIT,
		PUS_ERASED,
		PUS_USER
	} pus_state_t;
endpackage : pus_pkg
`default_nettype wire

// ==== core/pus_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// down counter: load starts a run, done pulses when it expires
// ----------------------------------------------------------------
module pus_timer #(
	parameter int WIDTH = 24
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic load,
	input wire logic abort,
	input wire logic [WIDTH-1:0] load_val,
	output logic busy,
	output logic done
);
	logic [WIDTH-1:0] cnt_r;
	logic busy_r;
	logic done_r;

	always_ff @(posedge sys_clk)
	begin
		if (!nrst || abort)
		begin
			cnt_r <= '0;
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end
		else if (load)
		begin
			// a zero load still waits one cycle
			cnt_r <= (load_val == '0) ? WIDTH'(1) : load_val;
			busy_r <= 1'b1;
			done_r <= 1'b0;
		end
		else if (busy_r)
		begin
			cnt_r <= cnt_r - WIDTH'(1);
			if (cnt_r == WIDTH'(1))
			begin
				busy_r <= 1'b0;
				done_r <= 1'b1;
			end
		end
		else
		begin
			done_r <= 1'b0;
		end
	end

	assign busy = busy_r;
	assign done = done_r;
endmodule : pus_timer
`default_nettype wire

// ==== core/pus_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none
module pus_sequencer #(
	parameter int N_PINS = 8,
	parameter int INIT_CYCLES = pus_pkg::INIT_CYCLES
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire pus_pkg::pus_apb_req_t apb_req,
	output pus_pkg::pus_apb_rsp_t apb_rsp,
	input wire logic core_supply_level_good,
	output logic [N_PINS-1:0] pin_io_cell_out,
	output logic [N_PINS-1:0] pin_io_cell_oe_n,
	output logic pin_io_cell_pullup_en,
	output logic pin_io_cell_bus_hold_en,
	output logic input_en,
	output logic clock_in_en,
	output logic func_block_en,
	output logic test_port_en,
	output logic op_ready
);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic reg_hit(
		input logic [pus_pkg::ADDR_W-1:0] addr,
		input logic [pus_pkg::ADDR_W-1:0] off
	);
		reg_hit = (addr == off);
	endfunction : reg_hit

	// ----------------------------------------------------------------
	// power-good synchroniser
	// ----------------------------------------------------------------
	logic pgood_meta_r;
	logic pgood_r;

	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			pgood_meta_r <= 1'b0;
			pgood_r <= 1'b0;
		end
		else
		begin
			pgood_meta_r <= core_supply_level_good;
			pgood_r <= pgood_meta_r;
		end
	end

	// ----------------------------------------------------------------
	// register bus
	// ----------------------------------------------------------------
	logic wr_access;
	logic rd_setup;
	logic addr_ok;
	logic programmed_r;
	logic [pus_pkg::INIT_CNT_W-1:0] init_cnt_r;
	logic [N_PINS-1:0] user_oe_r;
	logic [N_PINS-1:0] user_out_r;
	logic [pus_pkg::DATA_W-1:0] prdata_r;
	logic [pus_pkg::DATA_W-1:0] rd_val;
	logic [pus_pkg::DATA_W-1:0] status_val;
	logic timer_busy;
	logic timer_done;
	pus_pkg::pus_state_t state_r;

	assign wr_access = apb_req.psel && apb_req.penable && apb_req.pwrite;
	assign rd_setup = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
	assign addr_ok = reg_hit(apb_req.paddr, pus_pkg::OFF_CTRL)
		|| reg_hit(apb_req.paddr, pus_pkg::OFF_INIT)
		|| reg_hit(apb_req.paddr, pus_pkg::OFF_STATUS)
		|| reg_hit(apb_req.paddr, pus_pkg::OFF_USER_OE)
		|| reg_hit(apb_req.paddr, pus_pkg::OFF_USER_OUT);

	// the programmed flag stands in for the nonvolatile pattern store;
	// it is sampled only when the init interval ends, so a write during init still counts for this power-up
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
			programmed_r <= pus_pkg::CTRL_PROGRAMMED_RST;
		else if (wr_access && reg_hit(apb_req.paddr, pus_pkg::OFF_CTRL))
			programmed_r <= apb_req.pwdata[pus_pkg::CTRL_PROGRAMMED_BIT];
	end

	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
			init_cnt_r <= pus_pkg::INIT_CNT_W'(INIT_CYCLES);
		else if (wr_access && reg_hit(apb_req.paddr, pus_pkg::OFF_INIT))
			init_cnt_r <= apb_req.pwdata[pus_pkg::INIT_CNT_W-1:0];
	end

	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			user_oe_r <= '0;
			user_out_r <= '0;
		end
		else if (wr_access)
		begin
			if (reg_hit(apb_req.paddr, pus_pkg::OFF_USER_OE))
				user_oe_r <= apb_req.pwdata[N_PINS-1:0];
			if (reg_hit(apb_req.paddr, pus_pkg::OFF_USER_OUT))
				user_out_r <= apb_req.pwdata[N_PINS-1:0];
		end
	end

	always_comb
	begin
		status_val = '0;
		status_val[pus_pkg::STAT_STATE_LSB +: pus_pkg::STAT_STATE_W] = state_r;
		status_val[pus_pkg::STAT_PGOOD_BIT] = pgood_r;
		status_val[pus_pkg::STAT_READY_BIT] = op_ready;
		status_val[pus_pkg::STAT_INIT_BUSY_BIT] = timer_busy;
	end

	always_comb
	begin
		rd_val = '0;
		if (reg_hit(apb_req.paddr, pus_pkg::OFF_CTRL))
			rd_val[pus_pkg::CTRL_PROGRAMMED_BIT] = programmed_r;
		else if (reg_hit(apb_req.paddr, pus_pkg::OFF_INIT))
			rd_val[pus_pkg::INIT_CNT_W-1:0] = init_cnt_r;
		else if (reg_hit(apb_req.paddr, pus_pkg::OFF_STATUS))
			rd_val = status_val;
		else if (reg_hit(apb_req.paddr, pus_pkg::OFF_USER_OE))
			rd_val[N_PINS-1:0] = user_oe_r;
		else if (reg_hit(apb_req.paddr, pus_pkg::OFF_USER_OUT))
			rd_val[N_PINS-1:0] = user_out_r;
	end

	// read data is captured in the setup cycle so it comes from a flop
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
			prdata_r <= '0;
		else if (rd_setup)
			prdata_r <= rd_val;
	end

	// one driver for the whole response word
	assign apb_rsp = '{
		prdata: prdata_r,
		pready: 1'b1,
		pslverr: apb_req.psel && apb_req.penable && !addr_ok
	};

	// ----------------------------------------------------------------
	// power-up state machine
	// ----------------------------------------------------------------
	logic timer_load;
	pus_pkg::pus_state_t state_nxt;

	pus_timer #(
		.WIDTH(pus_pkg::INIT_CNT_W)
	) pus_timer_inst (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.load(timer_load),
		.abort(!pgood_r),
		.load_val(init_cnt_r),
		.busy(timer_busy),
		.done(timer_done)
	);

	always_comb
	begin
		state_nxt = state_r;
		timer_load = 1'b0;
		case (state_r)
			pus_pkg::PUS_QUIESCENT:
			begin
				if (pgood_r)
				begin
					state_nxt = pus_pkg::PUS_INIT;
					timer_load = 1'b1;
				end
			end
			pus_pkg::PUS_INIT:
			begin
				if (timer_done)
					state_nxt = programmed_r ? pus_pkg::PUS_USER : pus_pkg::PUS_ERASED;
			end
			pus_pkg::PUS_ERASED:
				state_nxt = pus_pkg::PUS_ERASED;
			pus_pkg::PUS_USER:
				state_nxt = pus_pkg::PUS_USER;
			default:
				state_nxt = pus_pkg::PUS_QUIESCENT;
		endcase
		// a supply dip drops the device back to quiescent from anywhere
		if (!pgood_r)
		begin
			state_nxt = pus_pkg::PUS_QUIESCENT;
			timer_load = 1'b0;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
			state_r <= pus_pkg::PUS_QUIESCENT;
		else
			state_r <= state_nxt;
	end

	// ----------------------------------------------------------------
	// pin and block enables, all from flops
	// ----------------------------------------------------------------
	logic user_mode;
	logic up_mode;
	logic [N_PINS-1:0] oe_n_r;
	logic [N_PINS-1:0] out_r;
	logic ctl_user_r;
	logic ctl_up_r;

	assign user_mode = (state_nxt == pus_pkg::PUS_USER);
	assign up_mode = (state_nxt == pus_pkg::PUS_USER) || (state_nxt == pus_pkg::PUS_ERASED);

	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			ctl_user_r <= 1'b0;
			ctl_up_r <= 1'b0;
		end
		else
		begin
			ctl_user_r <= user_mode;
			ctl_up_r <= up_mode;
		end
	end

	generate
		for (genvar i = 0; i < N_PINS; i++)
		begin : g_pin
			always_ff @(posedge sys_clk)
			begin
				if (!nrst)
				begin
					oe_n_r[i] <= 1'b1;
					out_r[i] <= 1'b0;
				end
				else
				begin
					// erased or quiescent: never drive
					oe_n_r[i] <= !(user_mode && user_oe_r[i]);
					out_r[i] <= user_mode && user_out_r[i];
				end
			end
		end
	endgenerate

	assign pin_io_cell_oe_n = oe_n_r;
	assign pin_io_cell_out = out_r;
	assign pin_io_cell_pullup_en = !ctl_user_r;
	assign pin_io_cell_bus_hold_en = ctl_user_r;
	assign input_en = ctl_user_r;
	assign clock_in_en = ctl_user_r;
	assign func_block_en = ctl_user_r;
	assign test_port_en = ctl_up_r;
	assign op_ready = ctl_up_r;
endmodule : pus_sequencer
`default_nettype wire

// ==== sim/pus_supply_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// board supply monitor: power-good rises a chosen number of cycles after
// the supply is switched on, and drops at once when it is switched off
module pus_supply_model (
	input wire logic sys_clk,
	input wire logic supply_on,
	input wire logic [7:0] ramp_cycles,
	output logic pgood
);
	logic [7:0] ramp_r;

	always_ff @(posedge sys_clk)
	begin
		if (!supply_on)
		begin
			ramp_r <= 8'h00;
			pgood <= 1'b0;
		end
		else if (ramp_r >= ramp_cycles)
			pgood <= 1'b1;
		else
			ramp_r <= ramp_r + 8'h01;
	end
endmodule : pus_supply_model
`default_nettype wire

// ==== sim/pus_sequencer_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module pus_sequencer_sva #(
	parameter int N_PINS = 8,
	parameter int INIT_CYCLES = 20
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic core_supply_level_good,
	input wire logic [N_PINS-1:0] pin_io_cell_oe_n,
	input wire logic pin_io_cell_pullup_en,
	input wire logic pin_io_cell_bus_hold_en,
	input wire logic input_en,
	input wire logic clock_in_en,
	input wire logic func_block_en,
	input wire logic test_port_en,
	input wire logic op_ready
);
	// cycles of unbroken power-good; saturates so it never wraps
	logic [15:0] good_cnt_r;

	always_ff @(posedge sys_clk)
	begin
		if (!nrst || !core_supply_level_good)
			good_cnt_r <= 16'h0000;
		else if (good_cnt_r != 16'hffff)
			good_cnt_r <= good_cnt_r + 16'h0001;
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	quiet_pins_a: assert property (!input_en |-> &pin_io_cell_oe_n && pin_io_cell_pullup_en)
		else $error("pin driven outside user operation");
	user_set_a: assert property (input_en |-> clock_in_en && func_block_en && test_port_en
		&& pin_io_cell_bus_hold_en && !pin_io_cell_pullup_en)
		else $error("user operation incomplete");
	core_off_a: assert property (!test_port_en |-> !input_en && !clock_in_en && !func_block_en)
		else $error("logic enabled while quiescent");
	ready_port_a: assert property (op_ready == test_port_en)
		else $error("test port and ready disagree");
	drop_quiet_a: assert property ($fell(core_supply_level_good) |-> ##[1:4] !test_port_en)
		else $error("no return to quiescent");
	init_time_a: assert property ($rose(op_ready) |-> good_cnt_r >= INIT_CYCLES
		&& good_cnt_r <= INIT_CYCLES + 8)
		else $error("init interval wrong");
	init_bound_a: assert property (good_cnt_r == INIT_CYCLES + 9 |-> op_ready)
		else $error("not ready after init");
	reset_quiet_a: assert property ($rose(nrst) |-> !op_ready && !input_en)
		else $error("not quiescent after reset");
endmodule : pus_sequencer_sva

bind pus_sequencer pus_sequencer_sva #(.N_PINS(N_PINS), .INIT_CYCLES(INIT_CYCLES))
	pus_sequencer_sva_inst (.sys_clk(sys_clk), .nrst(nrst),
	.core_supply_level_good(core_supply_level_good), .pin_io_cell_oe_n(pin_io_cell_oe_n),
	.pin_io_cell_pullup_en(pin_io_cell_pullup_en),
	.pin_io_cell_bus_hold_en(pin_io_cell_bus_hold_en), .input_en(input_en),
	.clock_in_en(clock_in_en), .func_block_en(func_block_en),
	.test_port_en(test_port_en), .op_ready(op_ready));
`default_nettype wire

// ==== sim/pus_sequencer_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK_EQ(g, e) if ((g) !== (e)) begin num_errors++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end samples_checked++;
module pus_sequencer_tb;
	logic sys_clk, nrst, pgood, supply_on, smp;
	logic [7:0] ramp, oe, uo, out, oe_n;
	logic pull, hold, ien, cen, fen, ten, rdy;
	logic [32:0] head;
	pus_pkg::pus_apb_req_t req;
	pus_pkg::pus_apb_rsp_t rsp;
	logic [32:0] expq[$];
	int num_errors, samples_checked;
	wire [31:0] pins = {9'h000, rdy, ten, ien, cen, fen, pull, hold, oe_n, out & ~oe_n};

	pus_sequencer #(.INIT_CYCLES(20)) pus_sequencer_inst (.sys_clk(sys_clk), .nrst(nrst),
		.apb_req(req), .apb_rsp(rsp), .core_supply_level_good(pgood),
		.pin_io_cell_out(out), .pin_io_cell_oe_n(oe_n), .pin_io_cell_pullup_en(pull),
		.pin_io_cell_bus_hold_en(hold), .input_en(ien), .clock_in_en(cen),
		.func_block_en(fen), .test_port_en(ten), .op_ready(rdy));
	pus_supply_model pus_supply_model_inst (.sys_clk(sys_clk), .supply_on(supply_on),
		.ramp_cycles(ramp), .pgood(pgood));

	initial
	begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	// ----------------------------------------------------------------
	// result monitor: each read or pin sample takes the oldest note
	// ----------------------------------------------------------------
	always @(posedge sys_clk)
		if ((req.psel && req.penable && rsp.pready && !req.pwrite) || smp)
		begin
			head = expq.pop_front();
			`CHK_EQ(smp ? {1'b0, pins} : {rsp.pslverr, rsp.prdata}, head)
		end

	// err is the slave error flag that a read is expected to report
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [31:0] e, input logic err = 1'b0);
		if (!w)
			expq.push_back({err, e});
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge sys_clk);
		req.penable <= 1'b1;
		do @(posedge sys_clk); while (rsp.pready !== 1'b1);
		req <= '0;
		@(posedge sys_clk);
	endtask : apb

	task automatic pin_chk(input logic [31:0] e);
		expq.push_back({1'b0, e});
		smp <= 1'b1;
		@(posedge sys_clk);
		smp <= 1'b0;
		@(posedge sys_clk);
	endtask : pin_chk

	task automatic wait_rdy(input logic lvl);
		int n;
		n = 0;
		while (rdy !== lvl && n < 200)
		begin
			@(posedge sys_clk);
			n++;
		end
		if (n >= 200)
			num_errors++;
	endtask : wait_rdy

	task automatic report_and_stop();
		if (num_errors == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : report_and_stop

	initial
	begin
		repeat (5000) @(posedge sys_clk);
		num_errors++;
		report_and_stop();
	end

	initial
	begin
		void'($urandom(32'h3d0c_91bd));
		nrst = 1'b0;
		req = '0;
		supply_on = 1'b0;
		smp = 1'b0;
		ramp = 8'h00;
		repeat (20) @(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk);
		apb(1'b0, pus_pkg::OFF_CTRL, 32'h0000_0000, 32'h0000_0000);
		apb(1'b0, pus_pkg::OFF_INIT, 32'h0000_0000, 32'h0000_0014);
		apb(1'b0, pus_pkg::OFF_STATUS, 32'h0000_0000, 32'h0000_0000);
		apb(1'b0, 12'h100, 32'h0000_0000, 32'h0000_0000, 1'b1);
		pin_chk(32'h0002_ff00);
		ramp <= 8'($urandom_range(40, 0));
		supply_on <= 1'b1;
		wait_rdy(1'b1);
		pin_chk(32'h0062_ff00);
		apb(1'b0, pus_pkg::OFF_STATUS, 32'h0000_0000, 32'h0000_000e);
		oe = 8'($urandom);
		uo = 8'($urandom);
		apb(1'b1, pus_pkg::OFF_USER_OE, {24'h00_0000, oe}, 32'h0000_0000);
		apb(1'b1, pus_pkg::OFF_USER_OUT, {24'h00_0000, uo}, 32'h0000_0000);
		apb(1'b1, pus_pkg::OFF_CTRL, 32'h0000_0001, 32'h0000_0000);
		// 22 init cycles keep the checker's interval window satisfied
		apb(1'b1, pus_pkg::OFF_INIT, 32'h0000_0016, 32'h0000_0000);
		apb(1'b0, pus_pkg::OFF_INIT, 32'h0000_0000, 32'h0000_0016);
		// programmed flag written outside init only counts from the next power-up
		apb(1'b0, pus_pkg::OFF_STATUS, 32'h0000_0000, 32'h0000_000e);
		supply_on <= 1'b0;
		ramp <= 8'h00;
		repeat (6) @(posedge sys_clk);
		pin_chk(32'h0002_ff00);
		supply_on <= 1'b1;
		repeat (8) @(posedge sys_clk);
		pin_chk(32'h0002_ff00);
		apb(1'b0, pus_pkg::OFF_STATUS, 32'h0000_0000, 32'h0000_0015);
		supply_on <= 1'b0;
		repeat (6) @(posedge sys_clk);
		ramp <= 8'($urandom_range(40, 0));
		supply_on <= 1'b1;
		wait_rdy(1'b1);
		pin_chk({9'h000, 7'h7d, ~oe, uo & oe});
		apb(1'b0, pus_pkg::OFF_STATUS, 32'h0000_0000, 32'h0000_000f);
		supply_on <= 1'b0;
		wait_rdy(1'b0);
		pin_chk(32'h0002_ff00);
		report_and_stop();
	end
endmodule : pus_sequencer_tb
`default_nettype wire
